// >>> lsd_pkg.sv
// Constants shared by the legacy segment descriptor checker and its decoder.
// Assumes a plain register port with byte addresses and 32-bit data.
package lsd_pkg;

  // ----------------------------------------------------------------
  // Register offsets (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] LSD_OFF_DESC_LO = 8'h00;
  localparam logic [7:0] LSD_OFF_DESC_HI = 8'h04;
  localparam logic [7:0] LSD_OFF_OFFSET = 8'h08;
  localparam logic [7:0] LSD_OFF_CTRL = 8'h0c;
  localparam logic [7:0] LSD_OFF_CMD = 8'h10;
  localparam logic [7:0] LSD_OFF_STATUS = 8'h14;
  localparam logic [7:0] LSD_OFF_BASE = 8'h18;
  localparam logic [7:0] LSD_OFF_LIMIT = 8'h1c;
  localparam logic [7:0] LSD_OFF_ATTR = 8'h20;
  localparam logic [7:0] LSD_OFF_CS_BASE = 8'h24;
  localparam logic [7:0] LSD_OFF_CS_LIMIT = 8'h28;
  localparam logic [7:0] LSD_OFF_COUNT = 8'h2c;

  // ----------------------------------------------------------------
  // Descriptor field positions in the high doubleword
  // ----------------------------------------------------------------
  localparam int LSD_HI_BASE_LO_MSB = 7;
  localparam int LSD_HI_ACC = 8;
  localparam int LSD_HI_RD = 9;
  localparam int LSD_HI_CONF = 10;
  localparam int LSD_HI_CODE = 11;
  localparam int LSD_HI_CLASS = 12;
  localparam int LSD_HI_DPL_LSB = 13;
  localparam int LSD_HI_PRESENT = 15;
  localparam int LSD_HI_LIM_LSB = 16;
  localparam int LSD_HI_AVL = 20;
  localparam int LSD_HI_SIZE = 22;
  localparam int LSD_HI_GRAN = 23;
  localparam int LSD_HI_BASE_HI_LSB = 24;

  // Control register field positions
  localparam int LSD_CTRL_SIZE_LSB = 0;
  localparam int LSD_CTRL_CPL_LSB = 4;
  localparam int LSD_CTRL_OP_PREF = 8;
  localparam int LSD_CTRL_AD_PREF = 9;

  // Limit scaling: a 4096-byte block leaves twelve low offset bits free
  localparam int LSD_GRAN_BYTES = 4096;
  localparam logic [11:0] LSD_GRAN_FILL = 12'(LSD_GRAN_BYTES - 1);

  // Reset values
  localparam logic [31:0] LSD_RST_WORD = 32'h0000_0000;
  localparam logic [15:0] LSD_RST_COUNT = 16'h0000;

  // ----------------------------------------------------------------
  // Enumerations
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    LSD_KIND_READ = 2'b00,
    LSD_KIND_WRITE = 2'b01,
    LSD_KIND_LOAD_CS = 2'b10,
    LSD_KIND_NONE = 2'b11
  } lsd_kind_e;

  typedef enum logic [1:0] {
    LSD_FAULT_NONE = 2'b00,
    LSD_FAULT_GP = 2'b01,
    LSD_FAULT_NP = 2'b10
  } lsd_fault_e;

  typedef enum logic {
    LSD_ST_IDLE = 1'b0,
    LSD_ST_CHECK = 1'b1
  } lsd_state_e;

endpackage

// >>> lsd_dec_if.sv
// Carrier between the checker and its descriptor field decoder.
// Assumes both ends sit on the same clock; the decoder is combinational.
`timescale 1ns/10ps
interface lsd_dec_if;
  logic [31:0] desc_lo;
  logic [31:0] desc_hi;
  logic [31:0] base;
  logic [19:0] limit_raw;
  logic [31:0] limit_eff;
  logic [1:0] descriptor_privilege_level;
  logic user_seg;
  logic [3:0] seg_type;
  logic is_code;
  logic conforming;
  logic readable;
  logic accessed;
  logic present;
  logic gran;
  logic size32;
  logic size_valid;

  modport src (
    output desc_lo,
    output desc_hi,
    input base,
    input limit_raw,
    input limit_eff,
    input descriptor_privilege_level,
    input user_seg,
    input seg_type,
    input is_code,
    input conforming,
    input readable,
    input accessed,
    input present,
    input gran,
    input size32,
    input size_valid
  );

  modport dec (
    input desc_lo,
    input desc_hi,
    output base,
    output limit_raw,
    output limit_eff,
    output descriptor_privilege_level,
    output user_seg,
    output seg_type,
    output is_code,
    output conforming,
    output readable,
    output accessed,
    output present,
    output gran,
    output size32,
    output size_valid
  );
endinterface

// >>> lsd_decode.sv
// Field decoder for one 8-byte legacy segment descriptor.
// Assumes the low doubleword is byte +0 and the high doubleword byte +4.
`timescale 1ns/10ps
module lsd_decode
  import lsd_pkg::*;
(
  // Descriptor in, fields out
  lsd_dec_if.dec d
);

  // ----------------------------------------------------------------
  // Field extraction
  // ----------------------------------------------------------------
  assign d.base = {d.desc_hi[31:LSD_HI_BASE_HI_LSB], d.desc_hi[LSD_HI_BASE_LO_MSB:0], d.desc_lo[15:0]};
  assign d.limit_raw = {d.desc_hi[LSD_HI_LIM_LSB+3:LSD_HI_LIM_LSB], d.desc_lo[15:0]};
  assign d.gran = d.desc_hi[LSD_HI_GRAN];
  // A raw zero gives last offset 0 (one byte) or 4095 when scaled
  assign d.limit_eff = d.gran ? {d.limit_raw, LSD_GRAN_FILL} : {12'h000, d.limit_raw};
  assign d.user_seg = d.desc_hi[LSD_HI_CLASS];
  assign d.seg_type = d.desc_hi[LSD_HI_CODE:LSD_HI_ACC];
  assign d.descriptor_privilege_level = d.desc_hi[LSD_HI_DPL_LSB+1:LSD_HI_DPL_LSB];
  assign d.present = d.desc_hi[LSD_HI_PRESENT];

  // ----------------------------------------------------------------
  // Code type decode: 8 execute-only up to F conforming readable accessed
  // ----------------------------------------------------------------
  assign d.is_code = d.user_seg & d.seg_type[3];
  assign d.conforming = d.is_code & d.seg_type[2];
  assign d.readable = d.is_code & d.seg_type[1];
  assign d.accessed = d.seg_type[0];

  // Size bit carries no meaning for system descriptors
  assign d.size_valid = d.user_seg;
  assign d.size32 = d.user_seg & d.desc_hi[LSD_HI_SIZE];

endmodule

// >>> lsd_checker.sv
// Legacy segment descriptor checker: decodes a descriptor, checks one
// reference against it and reports the fault, loading the code shadow.
// Assumes a same-clock register master; reads answer one cycle later.
//
// What this block does
// - Descriptor is low word plus high word
// - Limit is high 19-16 over low 15-0
// - Base assembled from three descriptor pieces
// - Any byte beyond limit gives protection fault; a kind none command skips the limit check
// - Bit 12 class, bits 11-8 type
// - Privilege level taken from bits 14-13
// - Absent segment faults; presence never modified
// - Software bit 20 untouched and ignored
// - Bit 22 default size, user segments only
// - Granularity bit scales limit by 4096
// - Zero limit means one byte or 4096 bytes
// - Type bit 11 splits code from data
// - Writes through code segments are refused
// - Conforming keeps privilege; others need equal level
// - Code reads need the readable bit
// - Loading code register sets accessed flag
// - Code types 8 to F decoded
// - Size bit sets default operand/address size
//
// The plain strobed port and the placing of the registers were left to the implementer.
`timescale 1ns/10ps
module lsd_checker
  import lsd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // Check result
  output logic chk_done,
  output lsd_pkg::lsd_fault_e chk_fault,
  output logic cs_valid,
  output logic [1:0] cs_cpl,
  output logic cs_op32,
  output logic cs_addr32
);
  import lsd_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    lsd_state_e st;
    logic [31:0] desc_lo;
    logic [31:0] desc_hi;
    logic [31:0] offset;
    logic [3:0] acc_size;
    logic [1:0] current_privilege_level;
    logic op_pref;
    logic ad_pref;
    lsd_kind_e kind;
    logic done;
    logic done_pulse;
    lsd_fault_e fault;
    logic cs_valid;
    logic [31:0] cs_base;
    logic [31:0] cs_limit;
    logic cs_size32;
    logic [1:0] cs_cpl;
    logic [15:0] gp_cnt;
    logic [15:0] np_cnt;
    logic [31:0] rdata;
  } lsd_regs_s;

  lsd_regs_s s_r;
  lsd_regs_s s_nxt;

  lsd_dec_if dec_bus ();

  // ----------------------------------------------------------------
  // Descriptor decoder
  // ----------------------------------------------------------------
  assign dec_bus.desc_lo = s_r.desc_lo;
  assign dec_bus.desc_hi = s_r.desc_hi;

  lsd_decode u_decode (
    .d(dec_bus)
  );

  // ----------------------------------------------------------------
  // Check terms
  // ----------------------------------------------------------------
  logic [3:0] eff_size;
  logic [32:0] last_byte;
  logic limit_gp;
  logic read_gp;
  logic write_gp;
  logic load_gp;
  logic any_gp;
  lsd_fault_e fault_now;
  logic op32_now;
  logic ad32_now;
  logic [31:0] attr_word;
  logic [31:0] status_word;

  // Size 0 is taken as a single byte so a check always covers something
  assign eff_size = (s_r.acc_size == 4'h0) ? 4'h1 : s_r.acc_size;
  // Offset of the final byte touched, one bit wider to catch wrap
  assign last_byte = {1'b0, s_r.offset} + {29'h0000_0000, eff_size} - 33'h0_0000_0001;
  assign limit_gp = last_byte > {1'b0, dec_bus.limit_eff};

  // System descriptors cannot back a plain data reference
  assign read_gp = !dec_bus.user_seg | (dec_bus.is_code & !dec_bus.readable);
  assign write_gp = !dec_bus.user_seg | dec_bus.is_code;

  // Direct transfer: conforming needs descriptor level at or below
  // current, non-conforming needs equal; going inward is for gates only
  always_comb
  begin
    load_gp = 1'b0;
    if (!dec_bus.is_code)
    begin
      load_gp = 1'b1;
    end
    else if (dec_bus.conforming)
    begin
      load_gp = dec_bus.descriptor_privilege_level > s_r.current_privilege_level;
    end
    else
    begin
      load_gp = dec_bus.descriptor_privilege_level != s_r.current_privilege_level;
    end
  end

  always_comb
  begin
    any_gp = limit_gp;
    unique case (s_r.kind)
      LSD_KIND_READ:
      begin
        any_gp = limit_gp | read_gp;
      end
      LSD_KIND_WRITE:
      begin
        any_gp = limit_gp | write_gp;
      end
      LSD_KIND_LOAD_CS:
      begin
        any_gp = limit_gp | load_gp;
      end
      LSD_KIND_NONE:
      begin
        any_gp = 1'b0;
      end
    endcase
  end

  // Not-present outranks every other check
  always_comb
  begin
    if (!dec_bus.present)
    begin
      fault_now = LSD_FAULT_NP;
    end
    else if (any_gp)
    begin
      fault_now = LSD_FAULT_GP;
    end
    else
    begin
      fault_now = LSD_FAULT_NONE;
    end
  end

  // Prefixes flip the default sizes the code descriptor sets
  assign op32_now = dec_bus.size32 ^ s_r.op_pref;
  assign ad32_now = dec_bus.size32 ^ s_r.ad_pref;

  // ----------------------------------------------------------------
  // Readback words
  // ----------------------------------------------------------------
  assign attr_word = {
    14'h0000,
    ad32_now,
    op32_now,
    dec_bus.size_valid,
    dec_bus.size32,
    dec_bus.gran,
    dec_bus.present,
    dec_bus.accessed,
    dec_bus.readable,
    dec_bus.conforming,
    dec_bus.is_code,
    dec_bus.seg_type,
    dec_bus.user_seg,
    dec_bus.descriptor_privilege_level,
    1'b0
  };

  assign status_word = {
    23'h00_0000,
    s_r.cs_cpl,
    s_r.cs_valid,
    s_r.kind,
    s_r.fault,
    s_r.st == LSD_ST_CHECK,
    s_r.done
  };

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    s_nxt = s_r;
    s_nxt.done_pulse = 1'b0;
    s_nxt.rdata = LSD_RST_WORD;

    // Register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        LSD_OFF_DESC_LO:
        begin
          s_nxt.desc_lo = reg_wdata;
        end
        LSD_OFF_DESC_HI:
        begin
          s_nxt.desc_hi = reg_wdata;
        end
        LSD_OFF_OFFSET:
        begin
          s_nxt.offset = reg_wdata;
        end
        LSD_OFF_CTRL:
        begin
          s_nxt.acc_size = reg_wdata[LSD_CTRL_SIZE_LSB+3:LSD_CTRL_SIZE_LSB];
          s_nxt.current_privilege_level = reg_wdata[LSD_CTRL_CPL_LSB+1:LSD_CTRL_CPL_LSB];
          s_nxt.op_pref = reg_wdata[LSD_CTRL_OP_PREF];
          s_nxt.ad_pref = reg_wdata[LSD_CTRL_AD_PREF];
        end
        LSD_OFF_CMD:
        begin
          // A command during a running check is dropped
          if (s_r.st == LSD_ST_IDLE)
          begin
            s_nxt.kind = lsd_kind_e'(reg_wdata[1:0]);
            s_nxt.st = LSD_ST_CHECK;
            s_nxt.done = 1'b0;
          end
        end
        LSD_OFF_STATUS:
        begin
          if (reg_wdata[0])
          begin
            s_nxt.done = 1'b0;
          end
        end
        default:
        begin
        end
      endcase
    end

    // Check cycle; hardware updates land after the software ones
    if (s_r.st == LSD_ST_CHECK)
    begin
      s_nxt.st = LSD_ST_IDLE;
      s_nxt.done = 1'b1;
      s_nxt.done_pulse = 1'b1;
      s_nxt.fault = fault_now;
      if (fault_now == LSD_FAULT_GP)
      begin
        s_nxt.gp_cnt = s_r.gp_cnt + 16'h0001;
      end
      if (fault_now == LSD_FAULT_NP)
      begin
        s_nxt.np_cnt = s_r.np_cnt + 16'h0001;
      end
      if (s_r.kind == LSD_KIND_LOAD_CS && fault_now == LSD_FAULT_NONE)
      begin
        // Only the accessed bit is written back; presence and
        // the software bit keep whatever software stored
        s_nxt.desc_hi[LSD_HI_ACC] = 1'b1;
        s_nxt.cs_valid = 1'b1;
        s_nxt.cs_base = dec_bus.base;
        s_nxt.cs_limit = dec_bus.limit_eff;
        s_nxt.cs_size32 = dec_bus.size32;
        // Conforming target runs at the caller's level
        s_nxt.cs_cpl = dec_bus.conforming ? s_r.current_privilege_level : dec_bus.descriptor_privilege_level;
      end
    end

    // Register reads, answered next cycle
    if (reg_rd)
    begin
      unique case (reg_addr)
        LSD_OFF_DESC_LO:
        begin
          s_nxt.rdata = s_r.desc_lo;
        end
        LSD_OFF_DESC_HI:
        begin
          s_nxt.rdata = s_r.desc_hi;
        end
        LSD_OFF_OFFSET:
        begin
          s_nxt.rdata = s_r.offset;
        end
        LSD_OFF_CTRL:
        begin
          s_nxt.rdata = {22'h00_0000, s_r.ad_pref, s_r.op_pref, 2'b00, s_r.current_privilege_level, s_r.acc_size};
        end
        LSD_OFF_STATUS:
        begin
          s_nxt.rdata = status_word;
        end
        LSD_OFF_BASE:
        begin
          s_nxt.rdata = dec_bus.base;
        end
        LSD_OFF_LIMIT:
        begin
          s_nxt.rdata = dec_bus.limit_eff;
        end
        LSD_OFF_ATTR:
        begin
          s_nxt.rdata = attr_word;
        end
        LSD_OFF_CS_BASE:
        begin
          s_nxt.rdata = s_r.cs_base;
        end
        LSD_OFF_CS_LIMIT:
        begin
          s_nxt.rdata = s_r.cs_limit;
        end
        LSD_OFF_COUNT:
        begin
          s_nxt.rdata = {s_r.np_cnt, s_r.gp_cnt};
        end
        default:
        begin
          s_nxt.rdata = LSD_RST_WORD;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (!reset_n)
    begin
      s_r <= '0;
      s_r.kind <= LSD_KIND_NONE;
      s_r.gp_cnt <= LSD_RST_COUNT;
      s_r.np_cnt <= LSD_RST_COUNT;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata = s_r.rdata;
  assign chk_done = s_r.done_pulse;
  assign chk_fault = s_r.fault;
  assign cs_valid = s_r.cs_valid;
  assign cs_cpl = s_r.cs_cpl;
  // Prefixes apply per instruction; the shadow holds only the default
  assign cs_op32 = s_r.cs_size32;
  assign cs_addr32 = s_r.cs_size32;

endmodule

// >>> lsd_checker_monitor.sv
// Port assertions for the legacy segment descriptor checker.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/10ps
module lsd_checker_monitor
  import lsd_pkg::*;
(
  // Clock and reset
  input wire logic clk_sys,
  input wire logic reset_n,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  // Check result
  input wire logic chk_done,
  input wire lsd_pkg::lsd_fault_e chk_fault,
  input wire logic cs_valid,
  input wire logic [1:0] cs_cpl,
  input wire logic cs_op32,
  input wire logic cs_addr32
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  logic run_r;
  logic acc;
  logic [1:0] keep_r;
  logic size_r;
  logic [1:0] kind_r;
  assign acc = reg_wr && reg_addr == LSD_OFF_CMD && !run_r;
  // Software owns presence and the spare bit, so last write is the truth
  always_ff @(posedge clk_sys)
  begin
    run_r <= reset_n && acc;
    if (!reset_n)
    begin
      keep_r <= 2'b00;
      size_r <= 1'b0;
      kind_r <= 2'b11;
    end
    else
    begin
      if (reg_wr && reg_addr == LSD_OFF_DESC_HI)
      begin
        keep_r <= {reg_wdata[20], reg_wdata[15]};
        size_r <= reg_wdata[LSD_HI_SIZE];
      end
      if (acc)
        kind_r <= reg_wdata[1:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  property p_rdata_idle;
    !$past(reg_rd) |-> reg_rdata == 32'h0;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data not zero");
  property p_done_two;
    acc |-> ##2 chk_done;
  endproperty
  a_done_two: assert property (p_done_two) else $error("check done late");
  property p_done_pulse;
    chk_done |=> !chk_done;
  endproperty
  a_done_pulse: assert property (p_done_pulse) else $error("done too long");
  property p_fault_hold;
    !chk_done |-> $stable(chk_fault) && chk_fault != 2'b11;
  endproperty
  a_fault_hold: assert property (p_fault_hold) else $error("fault moved");
  property p_np_prio;
    chk_done |-> ((chk_fault == LSD_FAULT_NP) == !$past(keep_r[0]));
  endproperty
  a_np_prio: assert property (p_np_prio) else $error("presence fault wrong");
  property p_hi_keep;
    reg_rd && reg_addr == LSD_OFF_DESC_HI |=> {reg_rdata[20], reg_rdata[15]} == $past(keep_r);
  endproperty
  a_hi_keep: assert property (p_hi_keep) else $error("owned bit altered");
  property p_cs_hold;
    !chk_done |-> $stable({cs_valid, cs_cpl, cs_op32, cs_addr32});
  endproperty
  a_cs_hold: assert property (p_cs_hold) else $error("shadow moved");
  property p_cs_rise;
    $rose(cs_valid) |-> chk_done && chk_fault == LSD_FAULT_NONE;
  endproperty
  a_cs_rise: assert property (p_cs_rise) else $error("bad shadow load");
  property p_size_same;
    chk_done && chk_fault == LSD_FAULT_NONE && kind_r == 2'd2
      |-> cs_op32 == $past(size_r) && cs_addr32 == cs_op32;
  endproperty
  a_size_same: assert property (p_size_same) else $error("sizes differ");
endmodule

bind lsd_checker lsd_checker_monitor lsd_checker_monitor_inst (.clk_sys(clk_sys), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
  .chk_done(chk_done), .chk_fault(chk_fault), .cs_valid(cs_valid), .cs_cpl(cs_cpl),
  .cs_op32(cs_op32), .cs_addr32(cs_addr32));

// >>> lsd_sw_table.sv
// Software side: builds legacy descriptors in a small table.
// Assumes the bench copies entries into the checker's registers.
`timescale 1ns/10ps
module lsd_sw_table;
  logic [31:0] lo_mem [8];
  logic [31:0] hi_mem [8];
  // Flags f: g, d, spare, present, level[1:0], class
  task automatic put(input int i, input logic [31:0] b, input logic [19:0] l, input logic [3:0] t,
    input logic [6:0] f);
    // Base bits 15-0 share the limit's low half; upper half kept zero
    lo_mem[i] = {16'h0000, l[15:0]};
    // Reserved bit 21 always written zero
    hi_mem[i] = {b[31:24], f[6:5], 1'b0, f[4], l[19:16], f[3:0], t, b[23:16]};
  endtask
endmodule

// >>> test_legacy_segment_descriptor_checker.sv
// Self-checking bench for the descriptor checker.
// Assumes the software table model and the port monitor.
`timescale 1ns/10ps
module test_legacy_segment_descriptor_checker;
  import lsd_pkg::*;
  logic clk_sys;
  logic reset_n;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic chk_done;
  lsd_fault_e chk_fault;
  logic cs_valid;
  logic [1:0] cs_cpl;
  logic cs_op32;
  logic cs_addr32;
  int error_cnt;
  int compares;

  lsd_checker lsd_checker_inst (.clk_sys(clk_sys), .reset_n(reset_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chk_done(chk_done),
    .chk_fault(chk_fault), .cs_valid(cs_valid), .cs_cpl(cs_cpl), .cs_op32(cs_op32), .cs_addr32(cs_addr32));
  lsd_sw_table lsd_sw_table_inst ();

  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------
  // Access tasks
  // ----------------------------------------------------------------
  task automatic close_out();
    if (error_cnt == 0 && compares > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [31:0] m);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1;
    cmp(reg_rdata & m, exp);
    @(posedge clk_sys);
  endtask
  // Build entry i in the table, then hand it over with offset and control
  task automatic desc(input int i, input logic [19:0] l, input logic [3:0] t, input logic [6:0] f,
    input logic [31:0] ctl, input logic [31:0] off);
    lsd_sw_table_inst.put(i, 32'h1234_5678, l, t, f);
    wr(LSD_OFF_DESC_LO, lsd_sw_table_inst.lo_mem[i]);
    wr(LSD_OFF_DESC_HI, lsd_sw_table_inst.hi_mem[i]);
    wr(LSD_OFF_OFFSET, off);
    wr(LSD_OFF_CTRL, ctl);
  endtask
  // Done is awaited under a bound; a hang counts as a mismatch
  task automatic run(input logic [1:0] k, input lsd_fault_e f);
    int n;
    wr(LSD_OFF_CMD, {30'h0, k});
    n = 0;
    #1;
    while (chk_done !== 1'b1 && n < 8)
    begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    if (n == 8)
    begin
      error_cnt++;
      close_out();
    end
    cmp({30'h0, chk_fault}, {30'h0, f});
    @(posedge clk_sys);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  initial
  begin
    reset_n = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    error_cnt = 0;
    compares = 0;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    // Last kind reads as none after reset
    rd(LSD_OFF_STATUS, 32'h30, 32'hffff_ffff);
    rd(8'hfc, 32'h0, 32'hffff_ffff);
    desc(0, 20'h00fff, 4'ha, 7'h39, 32'h4, 32'hffc);
    rd(LSD_OFF_BASE, 32'h1234_0fff, 32'hffff_ffff);
    rd(LSD_OFF_LIMIT, 32'h0fff, 32'hffff_ffff);
    rd(LSD_OFF_ATTR, 32'h1a8, 32'h1fe);
    run(2'd0, LSD_FAULT_NONE);
    wr(LSD_OFF_OFFSET, 32'hffd);
    run(2'd0, LSD_FAULT_GP);
    wr(LSD_OFF_OFFSET, 32'h0);
    run(2'd1, LSD_FAULT_GP);
    run(2'd2, LSD_FAULT_NONE);
    rd(LSD_OFF_DESC_HI, lsd_sw_table_inst.hi_mem[0] | 32'h100, 32'hffff_ffff);
    cmp({28'h0, cs_valid, cs_op32, cs_addr32, 1'b0}, 32'he);
    // Zero and scaled limits
    desc(1, 20'h0, 4'ha, 7'h39, 32'h4, 32'h0);
    rd(LSD_OFF_LIMIT, 32'h0, 32'hffff_ffff);
    desc(2, 20'h0, 4'ha, 7'h79, 32'h4, 32'h0);
    rd(LSD_OFF_LIMIT, 32'h0fff, 32'hffff_ffff);
    desc(3, 20'h2, 4'ha, 7'h79, 32'h4, 32'h0);
    rd(LSD_OFF_LIMIT, 32'h2fff, 32'hffff_ffff);
    for (int k = 8; k < 16; k++)
    begin
      desc(4, 20'hfffff, 4'(k), 7'h39, 32'h4, 32'h0);
      run(2'd0, k[1] ? LSD_FAULT_NONE : LSD_FAULT_GP);
      run(2'd2, LSD_FAULT_NONE);
    end
    // Level 3 caller, level 0 targets
    desc(5, 20'hfffff, 4'he, 7'h59, 32'h134, 32'h0);
    rd(LSD_OFF_ATTR, 32'h1_0000, 32'h3_0000);
    run(2'd2, LSD_FAULT_NONE);
    cmp({30'h0, cs_cpl}, 32'h3);
    cmp({31'h0, cs_op32}, 32'h0);
    desc(5, 20'hfffff, 4'ha, 7'h59, 32'h34, 32'h0);
    run(2'd2, LSD_FAULT_GP);
    // Level 3 target, level 3 caller
    desc(5, 20'hfffff, 4'ha, 7'h5f, 32'h34, 32'h0);
    rd(LSD_OFF_ATTR, 32'h6, 32'h6);
    run(2'd2, LSD_FAULT_NONE);
    // Absent segment, also beyond its limit
    desc(6, 20'h0, 4'ha, 7'h31, 32'h4, 32'h10);
    run(2'd0, LSD_FAULT_NP);
    run(2'd2, LSD_FAULT_NP);
    rd(LSD_OFF_DESC_HI, lsd_sw_table_inst.hi_mem[6], 32'hffff_ffff);
    run(2'd3, LSD_FAULT_NP);
    // Data and system descriptors
    desc(7, 20'hfffff, 4'h2, 7'h39, 32'h4, 32'h0);
    rd(LSD_OFF_ATTR, 32'h8008, 32'h8108);
    run(2'd2, LSD_FAULT_GP);
    desc(7, 20'hfffff, 4'h2, 7'h38, 32'h4, 32'h0);
    rd(LSD_OFF_ATTR, 32'h0, 32'h8008);
    run(2'd0, LSD_FAULT_GP);
    // Reset between checks clears the shadow
    reset_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    reset_n <= 1'b1;
    @(posedge clk_sys);
    cmp({31'h0, cs_valid}, 32'h0);
    rd(LSD_OFF_STATUS, 32'h30, 32'hffff_ffff);
    close_out();
  end
endmodule
